// [spio_io.sv]
// Discrete I/O logic of a servo driver in speed preset mode.
//
// Operation
// RULE1: Run input starts motion, selected speed.
// RULE2: No run input holds zero speed.
// RULE3: Negative analog reference reverses direction.
// RULE4: Feed one reversed by direction parameter.
// RULE5: Alarm clear held 30 ms clears.
// RULE6: Overheat and overload wait for cooling.
// RULE7: Power cycle alarm survives alarm clear.
// RULE8: Clamp needs enable and method 0X/1X.
// RULE9: Method 0X uses analog limit reference.
// RULE10: Method 1X uses torque preset parameter.
// RULE11: Method 2X always clamps with preset.
// RULE12: Brake output follows two brake modes.
// RULE13: Speed match within detection width.
// RULE14: Target is preset or commanded speed.
// RULE15: Running cw above stop speed.
// RULE16: Running ccw above stop speed.
// RULE17: Stopped below stop detection speed.
// RULE18: Clamped output when torque is limited.
// RULE19: Internal limit from five preset values.
// RULE20: Servo ok 1.6 s after power, no alarm.
// RULE21: Battery alarm keeps servo ok on.
// RULE22: Two select inputs choose feed speed.
// RULE23: Drive enable with no fault, brake ok.
// RULE24: Both run inputs mean hold.
`timescale 1ns/10ps
`include "spio_regs.svh"
module spio_io import spio_pkg::*; #(
  parameter int SW          = 16,
  parameter int TW          = 16,
  parameter int CLEAR_CYC   = `SPIO_CLEAR_CYCLES,
  parameter int READY_CYC   = `SPIO_READY_CYCLES
) (
  input  wire logic          clk_i,                // 125 MHz clock.
  input  wire logic          rst_i,                // Power-up reset.
  input  wire logic          run_ccw_input_i,      // Run ccw pin.
  input  wire logic          run_cw_input_i,       // Run cw pin.
  input  wire logic          alarm_clear_input_i,  // Alarm clear pin.
  input  wire logic          torque_clamp_enable_input_i, // Clamp pin.
  input  wire logic          speed_select_a_i,     // Select a pin.
  input  wire logic          speed_select_b_i,     // Select b pin.
  input  wire logic          drive_enable_input_i, // Drive enable pin.
  input  wire logic          brake_confirm_i,      // Brake confirm pin.
  input  wire logic          ref_one_analog_i,     // Feed one analog.
  input  wire logic          ref_two_analog_i,     // Feed two analog.
  input  wire logic signed [SW-1:0] analog_reference_one_i, // Ref one.
  input  wire logic signed [SW-1:0] analog_reference_two_i, // Ref two.
  input  wire logic [SW-1:0] feed_preset_1_i,      // Feed one preset.
  input  wire logic [SW-1:0] feed_preset_2_i,      // Feed two preset.
  input  wire logic [SW-1:0] feed_preset_3_i,      // Feed three preset.
  input  wire logic [SW-1:0] feed_preset_4_i,      // Feed four preset.
  input  wire logic          feed1_reverse_i,      // Feed one reverse.
  input  wire logic [1:0]    torque_limit_method_i, // Limit method.
  input  wire logic [TW-1:0] torque_limit_ref_i,   // Analog limit.
  input  wire logic [TW-1:0] torque_preset_i,      // Torque preset.
  input  wire logic [TW-1:0] torque_preset_extra_a_i, // Extra preset a.
  input  wire logic [TW-1:0] torque_preset_extra_b_i, // Extra preset b.
  input  wire logic [TW-1:0] torque_preset_extra_c_i, // Extra preset c.
  input  wire logic [TW-1:0] torque_preset_extra_d_i, // Extra preset d.
  input  wire logic [2:0]    torque_preset_sel_i,  // Preset index 0..4.
  input  wire logic [TW-1:0] motor_peak_torque_i,  // Motor peak limit.
  input  wire logic [TW-1:0] torque_demand_i,      // Loop torque demand.
  input  wire logic signed [SW-1:0] actual_speed_i, // Measured speed.
  input  wire logic [SW-1:0] match_width_i,        // Detection width.
  input  wire logic          target_is_command_i,  // Target select.
  input  wire logic [SW-1:0] stop_speed_i,         // Stop speed.
  input  wire logic          brake_mode_a_i,       // Brake mode one.
  input  wire logic          brake_mode_b_i,       // Brake mode two.
  input  wire logic          driver_overheat_alarm_i, // Overheat event.
  input  wire logic          motor_overload_alarm_i,  // Overload event.
  input  wire logic          temp_ok_i,            // Temperature ok.
  input  wire logic          power_cycle_alarm_i,  // Power cycle event.
  input  wire logic          battery_low_alarm_i,  // Battery low event.
  input  wire logic          other_alarm_i,        // Other resettable.
  output logic               motion_o,             // Run commanded, not hold.
  output logic               dir_ccw_o,            // Commanded ccw.
  output logic signed [SW-1:0] speed_cmd_o,        // Signed speed cmd.
  output logic               position_hold_o,      // Zero speed hold.
  output logic               torque_limit_on_o,    // Clamp applied.
  output logic [TW-1:0]      torque_limit_o,       // Clamp value.
  output logic               drive_active_o,       // Drive operational.
  output logic [4:0]         alarm_o,              // Latched alarms.
  output logic               brake_drive_output_o, // Brake output.
  output logic               speed_match_output_o, // Speed match.
  output logic               running_cw_output_o,  // Running cw.
  output logic               running_ccw_output_o, // Running ccw.
  output logic               motor_stopped_output_o, // Stopped.
  output logic               torque_clamped_output_o, // Clamped.
  output logic               servo_ok_output_o     // Servo ok.
);
  localparam int NIN = 8;
  spio_sync_if #(.N(NIN)) pins ();
  assign pins.raw = {brake_confirm_i, drive_enable_input_i,
                     speed_select_b_i, speed_select_a_i,
                     torque_clamp_enable_input_i, alarm_clear_input_i,
                     run_cw_input_i, run_ccw_input_i};
  spio_sync #(.N(NIN)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (pins.src)
  );

  logic ccw_s, cw_s, clr_s, clamp_s, sel_a_s, sel_b_s, en_s, bconf_s;
  assign {bconf_s, en_s, sel_b_s, sel_a_s, clamp_s, clr_s, cw_s, ccw_s} =
    pins.sync;

  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] v);
    mag = v[SW-1] ? SW'(-v) : SW'(v);
  endfunction

  // Feed select decode.
  spio_feed_t feed;
  // RULE22: select decode
  assign feed = spio_feed_t'({sel_b_s, sel_a_s});

  logic [SW-1:0] feed_mag;
  logic          feed_neg;
  always_comb begin
    feed_mag = feed_preset_4_i;
    feed_neg = 1'b0;
    unique case (feed)
      SPIO_FEED1: begin
        // RULE3: analog polarity reverse
        feed_mag = ref_one_analog_i ? mag(analog_reference_one_i)
                                    : feed_preset_1_i;
        feed_neg = ref_one_analog_i & analog_reference_one_i[SW-1];
      end
      SPIO_FEED2: begin
        feed_mag = ref_two_analog_i ? mag(analog_reference_two_i)
                                    : feed_preset_2_i;
        feed_neg = ref_two_analog_i & analog_reference_two_i[SW-1];
      end
      SPIO_FEED3: feed_mag = feed_preset_3_i;
      SPIO_FEED4: feed_mag = feed_preset_4_i;
    endcase
  end

  // Alarm latches; the set wins over a clear in the same cycle.
  logic [31:0] clr_cnt_q;
  logic        clr_fire;
  // RULE5: 30 ms hold
  assign clr_fire = clr_s && (clr_cnt_q == 32'(CLEAR_CYC - 1));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_cnt_q <= 32'h0;
    end else if (!clr_s) begin
      clr_cnt_q <= 32'h0;
    end else if (clr_cnt_q != 32'(CLEAR_CYC)) begin
      clr_cnt_q <= clr_cnt_q + 32'h1;
    end
  end

  logic [4:0] alarm_q;
  logic [4:0] alarm_set;
  logic [4:0] alarm_clr;
  assign alarm_set = {other_alarm_i, battery_low_alarm_i,
                      power_cycle_alarm_i, motor_overload_alarm_i,
                      driver_overheat_alarm_i};
  // RULE6: thermal alarms wait
  // RULE7: power cycle alarm kept
  assign alarm_clr = clr_fire ? {1'b1, 1'b1, 1'b0, temp_ok_i, temp_ok_i}
                              : 5'h0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_q <= 5'h0;
    end else begin
      alarm_q <= alarm_set | (alarm_q & ~alarm_clr);
    end
  end

  logic fault;
  // RULE21: battery excluded
  assign fault = |(alarm_q & ~(5'h1 << `SPIO_ALARM_BATTERY));

  // Power-up timer for servo ok.
  logic [31:0] up_cnt_q;
  logic        up_done;
  assign up_done = (up_cnt_q == 32'(READY_CYC));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_cnt_q <= 32'h0;
    end else if (!up_done) begin
      up_cnt_q <= up_cnt_q + 32'h1;
    end
  end

  // Motion command.
  spio_motion_t motion;
  logic         dir_ccw;
  logic         active;
  // RULE23: enable gating
  assign active = en_s && !fault && up_done &&
                  (bconf_s == brake_drive_output_o);
  always_comb begin
    // RULE24: both runs hold
    // RULE2: no run holds
    if (!active || (cw_s == ccw_s)) begin
      motion = SPIO_HOLD;
    end else if (cw_s) begin
      motion = SPIO_RUN_CW;
    end else begin
      motion = SPIO_RUN_CCW;
    end
  end
  // RULE4: feed one reverse
  assign dir_ccw = (motion == SPIO_RUN_CCW) ^ feed_neg ^
                   ((feed == SPIO_FEED1) & feed1_reverse_i);

  logic signed [SW-1:0] cmd_d;
  // RULE1: start at feed speed
  assign cmd_d = (motion == SPIO_HOLD) ? '0 :
                 (dir_ccw ? $signed(feed_mag) : $signed(SW'(-feed_mag)));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      motion_o        <= 1'b0;
      dir_ccw_o       <= 1'b0;
      speed_cmd_o     <= '0;
      position_hold_o <= 1'b1;
      drive_active_o  <= 1'b0;
    end else begin
      motion_o        <= (motion != SPIO_HOLD);
      dir_ccw_o       <= (motion != SPIO_HOLD) && dir_ccw;
      speed_cmd_o     <= cmd_d;
      position_hold_o <= (motion == SPIO_HOLD);
      drive_active_o  <= active;
    end
  end

  // Torque limit selection.
  logic [TW-1:0] preset_lim;
  always_comb begin
    // RULE19: preset source
    unique case (torque_preset_sel_i)
      3'h1: preset_lim = torque_preset_extra_a_i;
      3'h2: preset_lim = torque_preset_extra_b_i;
      3'h3: preset_lim = torque_preset_extra_c_i;
      3'h4: preset_lim = torque_preset_extra_d_i;
      default: preset_lim = torque_preset_i;
    endcase
  end

  logic          lim_on;
  logic [TW-1:0] lim_val;
  always_comb begin
    lim_on  = 1'b0;
    lim_val = motor_peak_torque_i;
    unique case (torque_limit_method_i)
      // RULE8: enable gated
      // RULE9: analog source
      `SPIO_METHOD_ANALOG: begin
        lim_on  = clamp_s;
        lim_val = torque_limit_ref_i;
      end
      // RULE10: parameter source
      `SPIO_METHOD_PARAM: begin
        lim_on  = clamp_s;
        lim_val = preset_lim;
      end
      // RULE11: always clamped
      `SPIO_METHOD_ALWAYS: begin
        lim_on  = 1'b1;
        lim_val = preset_lim;
      end
      default: lim_on = 1'b0;
    endcase
    if (!lim_on || lim_val > motor_peak_torque_i) begin
      lim_val = motor_peak_torque_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      torque_limit_on_o       <= 1'b0;
      torque_limit_o          <= '0;
      torque_clamped_output_o <= 1'b0;
    end else begin
      torque_limit_on_o       <= lim_on;
      torque_limit_o          <= lim_val;
      // RULE18: clamp flag
      torque_clamped_output_o <= (torque_demand_i >= lim_val);
    end
  end

  // Speed status outputs.
  logic [SW-1:0] act_mag;
  logic [SW-1:0] target_mag;
  logic [SW-1:0] diff;
  assign act_mag = mag(actual_speed_i);
  // RULE14: target select
  assign target_mag = target_is_command_i ? mag(cmd_d) : feed_mag;
  assign diff = (act_mag > target_mag) ? SW'(act_mag - target_mag)
                                       : SW'(target_mag - act_mag);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_match_output_o   <= 1'b0;
      running_cw_output_o    <= 1'b0;
      running_ccw_output_o   <= 1'b0;
      motor_stopped_output_o <= 1'b1;
    end else begin
      // RULE13: width window
      speed_match_output_o   <= (diff <= match_width_i);
      // RULE15: cw above stop
      running_cw_output_o    <= actual_speed_i[SW-1] &&
                                (act_mag > stop_speed_i);
      // RULE16: ccw above stop
      running_ccw_output_o   <= !actual_speed_i[SW-1] &&
                                (act_mag > stop_speed_i);
      // RULE17: below stop
      motor_stopped_output_o <= (act_mag < stop_speed_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brake_drive_output_o <= 1'b0;
      servo_ok_output_o    <= 1'b0;
      alarm_o              <= 5'h0;
    end else begin
      // RULE12: brake modes
      brake_drive_output_o <= brake_mode_b_i ? (en_s && !fault)
                              : (brake_mode_a_i ? en_s : (en_s && up_done));
      // RULE20: power-up delay
      servo_ok_output_o    <= up_done && !fault;
      alarm_o              <= alarm_q;
    end
  end
endmodule // spio_io

// [spio_regs.svh]
// Constants for the speed preset discrete I/O logic.
`ifndef SPIO_REGS_SVH
`define SPIO_REGS_SVH
`define SPIO_CLK_MHZ        125
`define SPIO_CLEAR_HOLD_MS  30
`define SPIO_CLEAR_CYCLES   (`SPIO_CLEAR_HOLD_MS * 1000 * `SPIO_CLK_MHZ)
`define SPIO_READY_MS       1600
`define SPIO_READY_CYCLES   (`SPIO_READY_MS * 1000 * `SPIO_CLK_MHZ)
`define SPIO_METHOD_ANALOG  2'h0
`define SPIO_METHOD_PARAM   2'h1
`define SPIO_METHOD_ALWAYS  2'h2
`define SPIO_ALARM_OVERHEAT 0
`define SPIO_ALARM_OVERLOAD 1
`define SPIO_ALARM_PWRCYCLE 2
`define SPIO_ALARM_BATTERY  3
`endif

// [spio_pkg.sv]
// Types for the speed preset discrete I/O logic.
package spio_pkg;
  typedef enum logic [1:0] {SPIO_FEED1, SPIO_FEED2, SPIO_FEED3, SPIO_FEED4}
    spio_feed_t;
  typedef enum logic [1:0] {SPIO_HOLD, SPIO_RUN_CW, SPIO_RUN_CCW}
    spio_motion_t;
endpackage

// [spio_sync_if.sv]
// Bundle of synchronised discrete inputs between the I/O modules.
`timescale 1ns/10ps
interface spio_sync_if #(parameter int N = 8);
  logic [N-1:0] raw;
  logic [N-1:0] sync;
  modport src (input raw, output sync);
  modport dst (output raw, input sync);
endinterface

// [spio_sync.sv]
// Two-stage synchroniser for the 24 V discrete inputs.
`timescale 1ns/10ps
module spio_sync #(
  parameter int N = 8
) (
  input  wire logic   clk_i,  // Core clock.
  input  wire logic   rst_i,  // Async reset, high.
  spio_sync_if.src    bus     // Raw in, synced out.
);
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.sync = sync_q;
endmodule // spio_sync

// [spio_io_chk.sv]
// Port-level assertions for the speed preset discrete I/O block.
`timescale 1ns/10ps
module spio_io_chk #(
  parameter int SW = 16
) (
  input logic                 clk_i,                       // Clock.
  input logic                 rst_i,                       // Reset.
  input logic                 run_cw_input_i,              // Run cw.
  input logic                 run_ccw_input_i,             // Run ccw.
  input logic                 torque_clamp_enable_input_i, // Clamp pin.
  input logic [1:0]           torque_limit_method_i,       // Method.
  input logic signed [SW-1:0] actual_speed_i,              // Speed.
  input logic [SW-1:0]        stop_speed_i,                // Stop speed.
  input logic                 temp_ok_i,                   // Temp ok.
  input logic                 alarm_clear_input_i,         // Clear pin.
  input logic [4:0]           alarm_o,                     // Alarms.
  input logic                 position_hold_o,             // Hold.
  input logic                 torque_limit_on_o,           // Clamp on.
  input logic                 running_cw_output_o,         // Running cw.
  input logic                 running_ccw_output_o,        // Running ccw.
  input logic                 motor_stopped_output_o,      // Stopped.
  input logic                 servo_ok_output_o            // Servo ok.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_both_hold: assert property (
    (run_cw_input_i && run_ccw_input_i)[*4] |=> position_hold_o)
    else $error("Both run pins did not hold position.");
  chk_idle_hold: assert property (
    (!run_cw_input_i && !run_ccw_input_i)[*4] |=> position_hold_o)
    else $error("Idle run pins did not hold position.");
  chk_stop_flag: assert property (
    actual_speed_i == 0 && stop_speed_i != 0 |=> motor_stopped_output_o)
    else $error("Zero speed not reported as stopped.");
  chk_cw_sign: assert property (
    actual_speed_i > 0 |=> !running_cw_output_o)
    else $error("Running cw on a ccw speed.");
  chk_ccw_sign: assert property (
    actual_speed_i < 0 |=> !running_ccw_output_o)
    else $error("Running ccw on a cw speed.");
  chk_clamp_always: assert property (
    torque_limit_method_i == 2'h2 |=> torque_limit_on_o)
    else $error("Method two did not clamp.");
  chk_clamp_off: assert property (
    (!torque_clamp_enable_input_i)[*4] ##0 torque_limit_method_i != 2'h2
    |=> !torque_limit_on_o) else $error("Clamp applied while disabled.");
  chk_servo_alarm: assert property (
    (alarm_o[2:0] != 3'h0 || alarm_o[4])[*2] |-> !servo_ok_output_o)
    else $error("Servo ok shown with an alarm.");
  chk_pwr_latched: assert property (
    alarm_o[2] |=> alarm_o[2]) else $error("Power cycle alarm cleared.");
  chk_heat_hot: assert property (
    alarm_o[0] && !$past(temp_ok_i) |=> alarm_o[0])
    else $error("Overheat cleared while hot.");
  chk_clear_held: assert property (
    $fell(alarm_o[4]) |-> $past(alarm_clear_input_i, 4))
    else $error("Alarm cleared without a held clear pin.");
  cov_cw: cover property (running_cw_output_o);
  cov_clear: cover property ($fell(alarm_o[4]));
  cov_ref_clamp: cover property (torque_limit_on_o && !torque_limit_method_i);
endmodule // spio_io_chk

// [spio_ctl_model.sv]
// Machine controller model driving the run, select and clear pins.
`timescale 1ns/10ps
module spio_ctl_model (
  input  logic       clk_i,       // Clock.
  input  logic       rst_i,       // Reset.
  input  logic [1:0] run_i,       // Bit 0 cw, bit 1 ccw.
  input  logic [1:0] feed_i,      // Feed number less one.
  input  logic [7:0] clear_len_i, // Clear hold in cycles.
  input  logic       clear_go_i,  // Start a clear hold.
  input  logic       brake_i,     // Brake output seen.
  output logic       run_cw_o,    // Run cw pin.
  output logic       run_ccw_o,   // Run ccw pin.
  output logic       sel_a_o,     // Select a pin.
  output logic       sel_b_o,     // Select b pin.
  output logic       clear_o,     // Alarm clear pin.
  output logic       confirm_o    // Brake confirm pin.
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (clear_go_i) begin
      cnt_q <= clear_len_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // A real brake answers late, so confirm lags the brake by a cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      confirm_o <= 1'b0;
    end else begin
      confirm_o <= brake_i;
    end
  end
  assign {sel_b_o, sel_a_o} = feed_i;
  assign {run_ccw_o, run_cw_o} = run_i;
  assign clear_o = cnt_q != 8'h00;
endmodule // spio_ctl_model

// [tb_top.sv]
// Top testbench for the speed preset discrete I/O block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic clk_i, rst_i, run_ccw_input_i, run_cw_input_i, alarm_clear_input_i;
  logic torque_clamp_enable_input_i, speed_select_a_i, speed_select_b_i;
  logic drive_enable_input_i, brake_confirm_i, ref_one_analog_i, temp_ok_i;
  logic ref_two_analog_i, feed1_reverse_i, target_is_command_i, motion_o;
  logic brake_mode_a_i, brake_mode_b_i, driver_overheat_alarm_i, dir_ccw_o;
  logic motor_overload_alarm_i, power_cycle_alarm_i, battery_low_alarm_i;
  logic other_alarm_i, position_hold_o, torque_limit_on_o, drive_active_o;
  logic brake_drive_output_o, speed_match_output_o, running_cw_output_o;
  logic running_ccw_output_o, motor_stopped_output_o, servo_ok_output_o;
  logic torque_clamped_output_o, clr_go_q;
  logic signed [15:0] analog_reference_one_i, analog_reference_two_i;
  logic signed [15:0] actual_speed_i, speed_cmd_o;
  logic [15:0] feed_preset_1_i, feed_preset_2_i, feed_preset_3_i;
  logic [15:0] feed_preset_4_i, torque_limit_ref_i, torque_preset_i;
  logic [15:0] torque_preset_extra_a_i, torque_preset_extra_b_i;
  logic [15:0] torque_preset_extra_c_i, torque_preset_extra_d_i;
  logic [15:0] motor_peak_torque_i, torque_demand_i, match_width_i;
  logic [15:0] stop_speed_i, torque_limit_o;
  logic [1:0]  torque_limit_method_i, run_q, feed_q;
  logic [2:0]  torque_preset_sel_i;
  logic [4:0]  alarm_o;
  logic [7:0]  clr_len_q;
  int          errors, n_checks, cyc;
  // Short counts keep the run brief; expectations assume these values.
  spio_io #(.CLEAR_CYC(8), .READY_CYC(20)) u_dut (.*);
  spio_ctl_model u_ctl (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_q),
    .feed_i(feed_q), .clear_len_i(clr_len_q), .clear_go_i(clr_go_q),
    .brake_i(brake_drive_output_o), .run_cw_o(run_cw_input_i),
    .run_ccw_o(run_ccw_input_i), .sel_a_o(speed_select_a_i),
    .sel_b_o(speed_select_b_i), .clear_o(alarm_clear_input_i),
    .confirm_o(brake_confirm_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic step(input logic [1:0] f, input logic [1:0] r);
    @(posedge clk_i);
    {feed_q, run_q} <= {f, r};
  endtask
  task automatic clear(input logic [7:0] n);
    @(posedge clk_i);
    {clr_go_q, clr_len_q} <= {1'b1, n};
    @(posedge clk_i);
    clr_go_q <= 1'b0;
    tick(25);
  endtask
  task automatic power_up();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    `CHK("ok early", 1'b0, servo_ok_output_o)
    `CHK("hold reset", 1'b1, position_hold_o)
    tick(30);
    `CHK("ok ready", 1'b1, servo_ok_output_o)
    `CHK("alarms off", 5'h00, alarm_o)
  endtask
  task automatic t_feeds();
    for (int k = 0; k < 4; k++) begin
      step(2'(k), 2'h2);
      tick(6);
      `CHK("motion", 1'b1, motion_o)
      `CHK("dir ccw", 1'b1, dir_ccw_o)
      `CHK("feed speed", 16'((k + 1) * 256), speed_cmd_o)
    end
    step(2'h0, 2'h1);
    tick(6);
    `CHK("dir cw", 1'b0, dir_ccw_o)
    `CHK("cw speed", -16'sh0100, speed_cmd_o)
  endtask
  task automatic t_hold();
    step(2'h0, 2'h3);
    tick(6);
    `CHK("both hold", 1'b1, position_hold_o)
    `CHK("both still", 1'b0, motion_o)
    step(2'h0, 2'h0);
    tick(6);
    `CHK("idle hold", 1'b1, position_hold_o)
    step(2'h0, 2'h2);
    drive_enable_input_i <= 1'b0;
    tick(8);
    `CHK("disabled", 1'b0, drive_active_o)
    `CHK("off brake", 1'b0, brake_drive_output_o)
    @(posedge clk_i);
    drive_enable_input_i <= 1'b1;
    tick(10);
    `CHK("enabled", 1'b1, drive_active_o)
  endtask
  task automatic t_reverse();
    step(2'h0, 2'h2);
    feed1_reverse_i <= 1'b1;
    tick(6);
    `CHK("rev param", 1'b0, dir_ccw_o)
    @(posedge clk_i);
    {feed1_reverse_i, ref_one_analog_i} <= 2'h1;
    analog_reference_one_i <= -16'sd500;
    tick(6);
    `CHK("neg ref one", 1'b0, dir_ccw_o)
    step(2'h1, 2'h2);
    ref_two_analog_i <= 1'b1;
    analog_reference_two_i <= -16'sd500;
    tick(6);
    `CHK("neg ref two", 1'b0, dir_ccw_o)
    step(2'h0, 2'h0);
    {ref_one_analog_i, ref_two_analog_i} <= 2'h0;
  endtask
  task automatic t_torque();
    logic        on;
    logic [15:0] lim;
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge clk_i);
        torque_limit_method_i <= 2'(m);
        torque_clamp_enable_input_i <= e[0];
        tick(6);
        on = (e == 1 && m < 2) || m == 2;
        lim = !on ? 16'h1000 : (m == 0 ? 16'h0300 : 16'h0400);
        `CHK("clamp on", on, torque_limit_on_o)
        `CHK("clamp value", lim, torque_limit_o)
      end
    end
    for (int s = 1; s < 5; s++) begin
      @(posedge clk_i);
      {torque_limit_method_i, torque_preset_sel_i} <= {2'h2, 3'(s)};
      torque_demand_i <= 16'hffff;
      tick(3);
      `CHK("extra preset", 16'((s + 4) * 256), torque_limit_o)
      `CHK("clamped", 1'b1, torque_clamped_output_o)
    end
    @(posedge clk_i);
    {torque_limit_method_i, torque_preset_sel_i, torque_demand_i} <= '0;
    tick(3);
    `CHK("not clamped", 1'b0, torque_clamped_output_o)
  endtask
  task automatic t_status();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      actual_speed_i <= (i == 0) ? -16'sh0100 : 16'((i == 1) * 256);
      tick(3);
      `CHK("running cw", i == 0, running_cw_output_o)
      `CHK("running ccw", i == 1, running_ccw_output_o)
      `CHK("stopped", i == 2, motor_stopped_output_o)
    end
    step(2'h0, 2'h2);
    actual_speed_i <= 16'sh0102;
    tick(6);
    `CHK("match in", 1'b1, speed_match_output_o)
    @(posedge clk_i);
    actual_speed_i <= 16'sh0120;
    tick(3);
    `CHK("match out", 1'b0, speed_match_output_o)
    step(2'h0, 2'h0);
    {target_is_command_i, actual_speed_i} <= {1'b0, 16'sh0102};
    tick(6);
    `CHK("match preset", 1'b1, speed_match_output_o)
    @(posedge clk_i);
    {target_is_command_i, actual_speed_i} <= {1'b1, 16'sh0000};
  endtask
  task automatic t_alarm();
    @(posedge clk_i);
    battery_low_alarm_i <= 1'b1;
    @(posedge clk_i);
    battery_low_alarm_i <= 1'b0;
    tick(3);
    `CHK("battery", 5'h08, alarm_o)
    `CHK("ok battery", 1'b1, servo_ok_output_o)
    @(posedge clk_i);
    temp_ok_i <= 1'b0;
    {driver_overheat_alarm_i, motor_overload_alarm_i} <= 2'h3;
    {power_cycle_alarm_i, other_alarm_i} <= 2'h3;
    step(2'h0, 2'h2);
    {driver_overheat_alarm_i, motor_overload_alarm_i} <= 2'h0;
    {power_cycle_alarm_i, other_alarm_i} <= 2'h0;
    tick(6);
    `CHK("all alarms", 5'h1f, alarm_o)
    `CHK("ok alarm", 1'b0, servo_ok_output_o)
    `CHK("fault run", 1'b0, motion_o)
    @(posedge clk_i);
    brake_mode_b_i <= 1'b1;
    tick(2);
    `CHK("fault brake", 1'b0, brake_drive_output_o)
    clear(8'h03);
    `CHK("short clear", 5'h1f, alarm_o)
    clear(8'h0e);
    `CHK("hot clear", 5'h07, alarm_o)
    temp_ok_i <= 1'b1;
    clear(8'h0e);
    `CHK("cool clear", 5'h04, alarm_o)
    `CHK("ok pwr", 1'b0, servo_ok_output_o)
    step(2'h0, 2'h0);
    power_up();
  endtask
  initial begin
    {rst_i, run_q, feed_q, clr_go_q, clr_len_q} = 14'h2000;
    {torque_clamp_enable_input_i, ref_one_analog_i, ref_two_analog_i} = '0;
    {feed1_reverse_i, brake_mode_b_i, driver_overheat_alarm_i} = '0;
    {motor_overload_alarm_i, power_cycle_alarm_i, battery_low_alarm_i} = '0;
    {other_alarm_i, torque_limit_method_i, torque_preset_sel_i} = '0;
    {analog_reference_one_i, analog_reference_two_i, actual_speed_i} = '0;
    {brake_mode_a_i, drive_enable_input_i, temp_ok_i} = 3'h7;
    {target_is_command_i, torque_demand_i} = 17'h10000;
    {feed_preset_1_i, feed_preset_2_i} = {16'h0100, 16'h0200};
    {feed_preset_3_i, feed_preset_4_i} = {16'h0300, 16'h0400};
    {torque_limit_ref_i, torque_preset_i} = {16'h0300, 16'h0400};
    {torque_preset_extra_a_i, torque_preset_extra_b_i} = 32'h05000600;
    {torque_preset_extra_c_i, torque_preset_extra_d_i} = 32'h07000800;
    {motor_peak_torque_i, match_width_i} = {16'h1000, 16'h0004};
    stop_speed_i = 16'h0010;
    power_up();
    t_feeds();
    t_hold();
    t_reverse();
    t_torque();
    t_status();
    t_alarm();
    summarize();
  end
endmodule // tb_top
bind spio_io spio_io_chk #(.SW(SW)) u_chk (.*);
